// ---- design/chc_defs.svh ----
// Register offsets, field positions and reset values of the card host control bank
`ifndef CHC_DEFS_SVH
`define CHC_DEFS_SVH
`define CHC_OFF_CTRL      12'h000
`define CHC_OFF_MODE      12'h004
`define CHC_OFF_DTO       12'h008
`define CHC_OFF_SLOT      12'h00c
`define CHC_OFF_ARG       12'h010
`define CHC_OFF_CMD       12'h014
`define CHC_OFF_BLK       12'h018
`define CHC_OFF_CSTO      12'h01c
`define CHC_OFF_RSP0      12'h020
`define CHC_OFF_RSP3      12'h02c
`define CHC_OFF_RXW       12'h030
`define CHC_OFF_TXW       12'h034
`define CHC_OFF_STAT      12'h040
`define CHC_OFF_IEN_SET   12'h044
`define CHC_OFF_IEN_CLR   12'h048
`define CHC_OFF_IMASK     12'h04c
`define CHC_OFF_DMA       12'h050
`define CHC_OFF_CFG       12'h054
`define CHC_OFF_WPM       12'h0e4
`define CHC_OFF_WPS       12'h0e8
`define CHC_OFF_REV       12'h0fc
`define CHC_OFF_FIFO_LO   12'h200
`define CHC_B_IFACE_ON    0
`define CHC_B_IFACE_OFF   1
`define CHC_B_PS_ON       2
`define CHC_B_PS_OFF      3
`define CHC_B_RW_ON       4
`define CHC_B_RW_OFF      5
`define CHC_B_SOFT_RST    7
`define CHC_B_RDSTOP      11
`define CHC_B_WRSTOP      12
`define CHC_B_FORCE_BYTE_MODE       13
`define CHC_B_PAD_VALUE_SEL        14
`define CHC_STAT_RESET    32'h0c000025
`define CHC_STAT_TRANSFER_DONE_FLAG  27
`define CHC_REV_VALUE     32'h00000100
`define CHC_CMD_TRANSFER_COMMAND_LSB 16
`define CHC_CMD_TRANSFER_DIRECTION     18
`define CHC_CMD_TRTYP_LSB 19
`define CHC_CMD_SPECIAL_COMMAND_FIELD_LSB 8
`define CHC_TRANSFER_COMMAND_START   2'h1
`define CHC_TRANSFER_COMMAND_STOP    2'h2
`define CHC_TRTYP_SDIOBYTE 3'h4
`define CHC_SPECIAL_COMMAND_FIELD_BOOT_REQUEST_CODE 3'h6
`define CHC_SPECIAL_COMMAND_FIELD_BOOT_END_CODE 3'h7
`endif

// ---- design/chc_pkg.sv ----
// Types shared by the card host control bank
package chc_pkg;
  typedef enum logic [1:0] {CHC_BUS1, CHC_BUSRSV, CHC_BUS4, CHC_BUS8} chc_bus_t;
  typedef enum {CHC_IDLE, CHC_XFER, CHC_DONE} chc_state_t;
endpackage

// ---- design/chc_regs.sv ----
// Control and mode register bank of the card host interface, APB slave
// Functional notes
// - Transfer-done flag rises exactly when read or write sequence completes; soft reset also sets it.
// - Writing one to soft reset bit resets the interface; zero does nothing.
// - Read-wait on bit enables, off bit disables; zeros ignored.
// - Power save on with off bit zero enables; both ones disables.
// - Interface on with off zero enables; both ones disable wins.
// - Block length bits 31:16 of mode are shared with block register.
// - SDIO byte transfers ignore block length.
// - Manual write padding uses 0x00 or 0xFF by pad value select.
// - Force byte bit enables byte-wide transfers for odd block sizes.
// - Write clock stop halts card clock on full FIFO during writes.
// - Read clock stop halts card clock while FIFO full during reads.
// - Power save card clock is module clock over two times (two to divider power, plus one); divider unused.
// - Normal card clock is module clock over two times divider plus one.
// - Bus width code 0 one line, 2 four, 3 eight; 1 reserved.
`include "chc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module chc_regs (
  input  wire logic          SYS_CLK,
  input  wire logic          ARST_N,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          FIFO_FULL,
  input  wire logic          SEQ_END,
  output logic               IFACE_EN,
  output logic               READ_WAIT_EN,
  output logic               POWER_SAVE_EN,
  output logic               CARD_CLK_EN,
  output logic               CARD_CLK_STOP,
  output chc_pkg::chc_bus_t  CARD_BUS_WIDTH,
  output logic               BYTE_MODE,
  output logic      [7:0]    PAD_BYTE,
  output logic      [15:0]   XFER_LENGTH,
  output logic               XFER_READ,
  output logic               XFER_ACTIVE,
  output logic               BOOT_ACTIVE,
  output logic               DMA_EN,
  output logic               SOFT_RESET
);
  import chc_pkg::*;

  logic        wr_en;
  logic        rd_en;
  logic [31:0] mode_r;
  logic [31:0] dto_r;
  logic [31:0] slot_r;
  logic [31:0] arg_r;
  logic [15:0] block_count_r;
  logic [31:0] csto_r;
  logic [31:0] dma_r;
  logic [31:0] cfg_r;
  logic [31:0] wpm_r;
  logic        iface_r;
  logic        rwait_r;
  logic        psave_r;
  logic        soft_r;
  logic        ff_meta_r;
  logic        ff_sync_r;
  logic        end_meta_r;
  logic        end_sync_r;
  logic        end_d_r;
  logic        done_r;
  logic        dir_r;
  logic [2:0]  trtyp_r;
  logic        boot_r;
  logic [15:0] div_cnt_r;
  logic [15:0] div_lim;
  logic        clk_en_r;
  logic [31:0] rdata_nxt;
  chc_state_t  state_r;

  // Access phase strobes; zero wait states
  assign wr_en   = PSEL & PENABLE & PWRITE;
  assign rd_en   = PSEL & PENABLE & ~PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  // Pin inputs are asynchronous, so two stages before use
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ff_meta_r  <= 1'b0;
      ff_sync_r  <= 1'b0;
      end_meta_r <= 1'b0;
      end_sync_r <= 1'b0;
      end_d_r    <= 1'b0;
    end else begin
      ff_meta_r  <= FIFO_FULL;
      ff_sync_r  <= ff_meta_r;
      end_meta_r <= SEQ_END;
      end_sync_r <= end_meta_r;
      end_d_r    <= end_sync_r;
    end
  end

  // soft reset pulse, one cycle after the write
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      soft_r <= 1'b0;
    end else begin
      soft_r <= wr_en && PADDR == `CHC_OFF_CTRL && PWDATA[`CHC_B_SOFT_RST];
    end
  end
  assign SOFT_RESET = soft_r;

  // control strobes set or clear enable state
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      iface_r <= 1'b0;
      rwait_r <= 1'b0;
      psave_r <= 1'b0;
    end else if (soft_r) begin
      iface_r <= 1'b0;
      rwait_r <= 1'b0;
      psave_r <= 1'b0;
    end else if (wr_en && PADDR == `CHC_OFF_CTRL) begin
      if (PWDATA[`CHC_B_IFACE_OFF]) begin
        iface_r <= 1'b0;
      end else if (PWDATA[`CHC_B_IFACE_ON]) begin
        iface_r <= 1'b1;
      end
      if (PWDATA[`CHC_B_PS_OFF]) begin
        psave_r <= 1'b0;
      end else if (PWDATA[`CHC_B_PS_ON]) begin
        psave_r <= 1'b1;
      end
      if (PWDATA[`CHC_B_RW_OFF]) begin
        rwait_r <= 1'b0;
      end else if (PWDATA[`CHC_B_RW_ON]) begin
        rwait_r <= 1'b1;
      end
    end
  end

  // Configuration storage; soft reset clears it like a power-up
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_r <= 32'h00000000;
      dto_r  <= 32'h00000000;
      slot_r <= 32'h00000000;
      arg_r  <= 32'h00000000;
      block_count_r <= 16'h0000;
      csto_r <= 32'h00000000;
      dma_r  <= 32'h00000000;
      cfg_r  <= 32'h00000000;
      wpm_r  <= 32'h00000000;
    end else if (soft_r) begin
      mode_r <= 32'h00000000;
      dto_r  <= 32'h00000000;
      slot_r <= 32'h00000000;
      arg_r  <= 32'h00000000;
      block_count_r <= 16'h0000;
      csto_r <= 32'h00000000;
      dma_r  <= 32'h00000000;
      cfg_r  <= 32'h00000000;
      wpm_r  <= 32'h00000000;
    end else if (wr_en) begin
      case (PADDR)
        // bit 15 is reserved and always reads zero
        `CHC_OFF_MODE: mode_r <= {PWDATA[31:16], 1'b0, PWDATA[14:0]};
        `CHC_OFF_DTO:  dto_r  <= PWDATA;
        `CHC_OFF_SLOT: slot_r <= PWDATA;
        `CHC_OFF_ARG:  arg_r  <= PWDATA;
        // block register writes the shared length storage
        `CHC_OFF_BLK: begin
          mode_r[31:16] <= PWDATA[31:16];
          block_count_r        <= PWDATA[15:0];
        end
        `CHC_OFF_CSTO: csto_r <= PWDATA;
        `CHC_OFF_DMA:  dma_r  <= PWDATA;
        `CHC_OFF_CFG:  cfg_r  <= PWDATA;
        `CHC_OFF_WPM:  wpm_r  <= PWDATA;
        default: ;
      endcase
    end
  end

  // Transfer sequencer driven by command writes and the end pulse
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= CHC_IDLE;
      dir_r   <= 1'b0;
      trtyp_r <= 3'h0;
      boot_r  <= 1'b0;
    end else if (soft_r) begin
      state_r <= CHC_IDLE;
      boot_r  <= 1'b0;
    end else begin
      if (wr_en && PADDR == `CHC_OFF_CMD) begin
        if (PWDATA[`CHC_CMD_SPECIAL_COMMAND_FIELD_LSB +: 3] == `CHC_SPECIAL_COMMAND_FIELD_BOOT_REQUEST_CODE) begin
          boot_r <= 1'b1;
        end else if (PWDATA[`CHC_CMD_SPECIAL_COMMAND_FIELD_LSB +: 3] == `CHC_SPECIAL_COMMAND_FIELD_BOOT_END_CODE) begin
          boot_r <= 1'b0;
        end
      end
      case (state_r)
        CHC_IDLE, CHC_DONE: begin
          if (wr_en && PADDR == `CHC_OFF_CMD && iface_r &&
              PWDATA[`CHC_CMD_TRANSFER_COMMAND_LSB +: 2] == `CHC_TRANSFER_COMMAND_START) begin
            state_r <= CHC_XFER;
            dir_r   <= PWDATA[`CHC_CMD_TRANSFER_DIRECTION];
            trtyp_r <= PWDATA[`CHC_CMD_TRTYP_LSB +: 3];
          end
        end
        CHC_XFER: begin
          if (end_sync_r & ~end_d_r) begin
            state_r <= CHC_DONE;
          end else if (wr_en && PADDR == `CHC_OFF_CMD &&
                       PWDATA[`CHC_CMD_TRANSFER_COMMAND_LSB +: 2] == `CHC_TRANSFER_COMMAND_STOP) begin
            state_r <= CHC_DONE;
          end
        end
        default: state_r <= CHC_IDLE;
      endcase
    end
  end

  // done flag set in the cycle the sequence ends; a new start clears it
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_r <= 1'b1;
    end else if (soft_r) begin
      done_r <= 1'b1;
    end else if (state_r == CHC_XFER && end_sync_r && !end_d_r) begin
      done_r <= 1'b1;
    end else if (state_r == CHC_XFER) begin
      done_r <= 1'b0;
    end
  end

  // normal limit 2*(div+1) cycles per card period, half-period toggles
  // power save half period of 2^power_save_divider+1 cycles
  always_comb begin
    div_lim = {8'h00, mode_r[7:0]};
    if (psave_r) begin
      div_lim = 16'((16'h0001 << mode_r[10:8]));
    end
  end

  // Card clock enable: one pulse per half period of the card clock
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt_r <= 16'h0000;
      clk_en_r  <= 1'b0;
    end else if (!iface_r || CARD_CLK_STOP) begin
      // Stopped clock restarts its half-period count from zero; data integrity over bandwidth
      div_cnt_r <= 16'h0000;
      clk_en_r  <= 1'b0;
    end else if (div_cnt_r >= div_lim) begin
      div_cnt_r <= 16'h0000;
      clk_en_r  <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      clk_en_r  <= 1'b0;
    end
  end

  assign CARD_CLK_STOP = state_r == CHC_XFER && ff_sync_r &&
                         ((dir_r && mode_r[`CHC_B_RDSTOP]) || (!dir_r && mode_r[`CHC_B_WRSTOP]));
  assign CARD_CLK_EN   = clk_en_r;

  // bus width code straight from the slot register
  assign CARD_BUS_WIDTH = chc_bus_t'(slot_r[7:6]);
  assign BYTE_MODE      = mode_r[`CHC_B_FORCE_BYTE_MODE];
  assign PAD_BYTE       = mode_r[`CHC_B_PAD_VALUE_SEL] ? 8'hff : 8'h00;
  // length zeroed for SDIO byte transfers
  assign XFER_LENGTH    = (trtyp_r == `CHC_TRTYP_SDIOBYTE) ? 16'h0000 : mode_r[31:16];
  assign XFER_READ      = dir_r;
  assign XFER_ACTIVE    = state_r == CHC_XFER;
  assign BOOT_ACTIVE    = boot_r;
  assign DMA_EN         = dma_r[8];
  assign IFACE_EN       = iface_r;
  assign READ_WAIT_EN   = rwait_r;
  assign POWER_SAVE_EN  = psave_r;

  // read mux; write-only and unmapped words read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (PADDR)
      `CHC_OFF_MODE: rdata_nxt = mode_r;
      `CHC_OFF_DTO:  rdata_nxt = dto_r;
      `CHC_OFF_SLOT: rdata_nxt = slot_r;
      `CHC_OFF_ARG:  rdata_nxt = arg_r;
      `CHC_OFF_BLK:  rdata_nxt = {mode_r[31:16], block_count_r};
      `CHC_OFF_CSTO: rdata_nxt = csto_r;
      `CHC_OFF_STAT: begin
        rdata_nxt = `CHC_STAT_RESET;
        rdata_nxt[`CHC_STAT_TRANSFER_DONE_FLAG] = done_r;
      end
      `CHC_OFF_DMA:  rdata_nxt = dma_r;
      `CHC_OFF_CFG:  rdata_nxt = cfg_r;
      `CHC_OFF_WPM:  rdata_nxt = wpm_r;
      `CHC_OFF_REV:  rdata_nxt = `CHC_REV_VALUE;
      default:       rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data comes from the mux while the access phase is up
  assign PRDATA = rd_en ? rdata_nxt : 32'h00000000;
endmodule // chc_regs
`default_nettype wire

// ---- bench/chc_regs_assertions.sv ----
// Property checker for the card host control register bank
`timescale 1ns/1ps
`default_nettype none
module chc_regs_assertions (
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        SEQ_END,
  input wire logic        IFACE_EN,
  input wire logic        READ_WAIT_EN,
  input wire logic        POWER_SAVE_EN,
  input wire logic        BYTE_MODE,
  input wire logic [7:0]  PAD_BYTE,
  input wire logic        XFER_ACTIVE,
  input wire logic        SOFT_RESET
);
  logic        ctl_wr;
  logic        mode_wr;
  logic [31:0] wd_r;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // Decoded writes to control and mode words
  assign ctl_wr  = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
  assign mode_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
  // Write data one cycle back, for field checks
  always_ff @(posedge SYS_CLK) wd_r <= PWDATA;
  // Reset pulse followed by cleared enables
  sequence rst_clear;
    SOFT_RESET ##1 !IFACE_EN && !POWER_SAVE_EN && !READ_WAIT_EN;
  endsequence
  iface_on_a: assert property (
    ctl_wr && PWDATA[1:0] == 2'h1 |=> IFACE_EN) else $error("iface enable lost");
  iface_off_a: assert property (
    ctl_wr && PWDATA[1] |=> !IFACE_EN) else $error("iface disable lost");
  rwait_on_a: assert property (
    ctl_wr && PWDATA[5:4] == 2'h1 |=> READ_WAIT_EN) else $error("read wait enable lost");
  psave_on_a: assert property (
    ctl_wr && PWDATA[3:2] == 2'h1 |=> POWER_SAVE_EN) else $error("power save enable lost");
  zero_hold_a: assert property (
    ctl_wr && PWDATA[7:0] == 8'h00 && !SOFT_RESET |=> $stable(IFACE_EN) && $stable(READ_WAIT_EN)
    && $stable(POWER_SAVE_EN)) else $error("zero strobe changed state");
  soft_rst_a: assert property (
    ctl_wr && PWDATA[7] |-> ##[1:2] rst_clear) else $error("soft reset missing");
  mode_bits_a: assert property (
    mode_wr |=> BYTE_MODE == wd_r[13] && PAD_BYTE == {8{wd_r[14]}}) else $error("mode fields wrong");
  wo_read_a: assert property (
    PSEL && PENABLE && !PWRITE && (PADDR == 12'h000 || PADDR == 12'h014 || PADDR == 12'h034)
    |-> PRDATA == 32'h0) else $error("write-only word read nonzero");
  done_a: assert property (
    $rose(SEQ_END) && XFER_ACTIVE |-> ##[1:4] !XFER_ACTIVE) else $error("transfer end missed");
endmodule // chc_regs_assertions
bind chc_regs chc_regs_assertions u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .SEQ_END(SEQ_END), .IFACE_EN(IFACE_EN), .READ_WAIT_EN(READ_WAIT_EN), .POWER_SAVE_EN(POWER_SAVE_EN),
  .BYTE_MODE(BYTE_MODE), .PAD_BYTE(PAD_BYTE), .XFER_ACTIVE(XFER_ACTIVE), .SOFT_RESET(SOFT_RESET));
`default_nettype wire

// ---- bench/chc_card_model.sv ----
// Behavioural card model driving FIFO full and sequence end
`timescale 1ns/1ps
`default_nettype none
module chc_card_model #(
  parameter int BEATS = 6
) (
  input  wire logic clk,
  input  wire logic xfer_act,
  input  wire logic clk_en,
  input  wire logic clk_stop,
  input  wire logic stall,
  output logic      fifo_full = 1'b0,
  output logic      seq_end = 1'b0
);
  int beat_r = 0;
  // One beat per running card clock; a stopped clock freezes the card
  always_ff @(posedge clk) begin
    fifo_full <= stall && xfer_act;
    if (!xfer_act) begin
      beat_r  <= 0;
      seq_end <= 1'b0;
    end else if (clk_en && !clk_stop) begin
      beat_r  <= beat_r + 1;
      seq_end <= beat_r >= BEATS;
    end
  end
endmodule // chc_card_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the card host control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import chc_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, pready, stall;
  logic        fifo_full, seq_end, iface_en, rw_en, ps_en, clk_en, clk_stop;
  logic        byte_mode, xfer_rd, xfer_act, boot_act, dma_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, m;
  logic [15:0] xfer_len;
  logic [7:0]  pad_byte;
  logic [2:0]  exp_en;
  chc_bus_t    bus_w;
  int          seed, bad_count, cmp_count, g;
  localparam logic [11:0] RA [8] = '{12'h000, 12'h004, 12'h00c, 12'h018, 12'h014, 12'h040, 12'h050, 12'h038};
  localparam logic [31:0] RV [8] = '{0, 0, 0, 0, 0, 32'h0c000025, 0, 0};
  localparam logic [31:0] CORNER [6] = '{32'h01, 32'h00, 32'h03, 32'h15, 32'h00, 32'h2a};
  chc_regs u_dut (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .FIFO_FULL(fifo_full),
    .SEQ_END(seq_end), .IFACE_EN(iface_en), .READ_WAIT_EN(rw_en), .POWER_SAVE_EN(ps_en),
    .CARD_CLK_EN(clk_en), .CARD_CLK_STOP(clk_stop), .CARD_BUS_WIDTH(bus_w), .BYTE_MODE(byte_mode),
    .PAD_BYTE(pad_byte), .XFER_LENGTH(xfer_len), .XFER_READ(xfer_rd), .XFER_ACTIVE(xfer_act),
    .BOOT_ACTIVE(boot_act), .DMA_EN(dma_en), .SOFT_RESET());
  chc_card_model u_card (.clk(clk), .xfer_act(xfer_act), .clk_en(clk_en), .clk_stop(clk_stop),
    .stall(stall), .fifo_full(fifo_full), .seq_end(seq_end));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      finish_test;
    end
  endtask
  task automatic wait_act(input logic want);
    int n;
    n = 0;
    while (xfer_act !== want && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      bad_count++;
      finish_test;
    end
  endtask
  // Cycles between two card clock pulses
  task automatic gap(output int c);
    c = 0;
    while (clk_en !== 1'b1 && c < 100) begin
      @(posedge clk);
      c++;
    end
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (clk_en !== 1'b1 && c < 100);
    if (c >= 100) begin
      bad_count++;
      finish_test;
    end
  endtask
  // Expected enables after a strobe write; disable wins each pair
  function automatic logic [2:0] next_en(input logic [2:0] s, input logic [5:0] v);
    logic [2:0] r;
    r = s;
    if (v[1]) r[2] = 1'b0; else if (v[0]) r[2] = 1'b1;
    if (v[5]) r[1] = 1'b0; else if (v[4]) r[1] = 1'b1;
    if (v[3]) r[0] = 1'b0; else if (v[2]) r[0] = 1'b1;
    return r;
  endfunction
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, stall, arst_n} = '0;
    seed = 68;
    bad_count = 0;
    cmp_count = 0;
    exp_en = 3'h0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk(rd, RV[i]);
    end
    $display("end of test: reset values");
    // non-zero power save divider before any enable
    apb(1'b1, 12'h004, 32'h00000203);
    for (int i = 0; i < 24; i++) begin
      m = (i < 6) ? CORNER[i] : ($random(seed) & 32'h3f);
      apb(1'b1, 12'h000, m);
      exp_en = next_en(exp_en, m[5:0]);
      @(posedge clk);
      chk({29'h0, iface_en, rw_en, ps_en}, {29'h0, exp_en});
    end
    $display("end of test: strobes");
    apb(1'b1, 12'h000, 32'h09);
    gap(g);
    gap(g);
    chk(g, 4);
    apb(1'b1, 12'h000, 32'h04);
    gap(g);
    gap(g);
    chk(g, 5);
    apb(1'b1, 12'h000, 32'h08);
    $display("end of test: dividers");
    for (int i = 0; i < 8; i++) begin
      m = $random(seed);
      // word-multiple length unless byte forcing is on
      if (!m[13]) m[17:16] = 2'h0;
      m[10:0] = 11'h203;
      apb(1'b1, 12'h004, m);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, m & 32'hffff7fff);
      chk({7'h0, byte_mode, pad_byte, xfer_len}, {7'h0, m[13], {8{m[14]}}, m[31:16]});
      apb(1'b0, 12'h018, 32'h0);
      chk(rd & 32'hffff0000, m & 32'hffff0000);
    end
    $display("end of test: mode fields");
    // bus width, 512-byte blocks and count before boot
    apb(1'b1, 12'h00c, 32'hc0);
    @(posedge clk);
    chk({30'h0, bus_w}, {30'h0, CHC_BUS8});
    apb(1'b1, 12'h018, 32'h02000001);
    apb(1'b1, 12'h050, 32'h100);
    @(posedge clk);
    chk({31'h0, dma_en}, 32'h1);
    // block length written before any transfer command
    apb(1'b1, 12'h004, 32'h02001a03);
    for (int d = 1; d >= 0; d--) begin
      stall <= 1'b1;
      apb(1'b1, 12'h014, d ? 32'h00050600 : 32'h00010000);
      @(posedge clk);
      chk({29'h0, boot_act, xfer_rd, xfer_act}, {29'h0, d[0], d[0], 1'b1});
      repeat (4) @(posedge clk);
      chk({31'h0, clk_stop}, 32'h1);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h04000025);
      stall <= 1'b0;
      wait_act(1'b0);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0c000025);
      apb(1'b1, 12'h014, 32'h00000700);
      @(posedge clk);
      chk({31'h0, boot_act}, 32'h0);
    end
    $display("end of test: transfers");
    stall <= 1'b1;
    apb(1'b1, 12'h014, 32'h00210000);
    @(posedge clk);
    chk({16'h0, xfer_len}, 32'h0);
    apb(1'b1, 12'h014, 32'h00220000);
    wait_act(1'b0);
    stall <= 1'b0;
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h04000025);
    $display("end of test: byte mode and stop");
    apb(1'b1, 12'h000, 32'h81);
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk({rd[31:1], iface_en}, 32'h0);
    $display("end of test: soft reset");
    finish_test;
  end
endmodule // tb
`default_nettype wire
